// [bench/hbp_chk.sv]
// Purpose: Bus-level checks between the host and device ends.
// Assumes: Both ends share one clock and its synchronous reset.
// Notes:   Watches the interface wires only, not the APB side.
`default_nettype none
module hbp_chk (
  input wire logic       i_core_clk,           // Core clock
  input wire logic       i_srst,               // Sync reset
  input wire logic [1:0] bus_style_select,     // Strobe style
  input wire logic       mapper_select_n,      // Mapper select
  input wire logic       transceiver_select_n, // Transceiver select
  input wire logic [9:0] host_addr,            // Address pins
  input wire logic       rd_latch_strobe_n,    // Read or data strobe
  input wire logic       wr_dir_n,             // Write strobe or dir
  input wire logic       hw_reset_n,           // Reset pin
  input wire logic       host_data_oe,         // Host drives data
  input wire logic       dev_data_oe,          // Device drives data
  input wire logic       irq_n_oe              // Device drives irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  logic [3:0] since_rd;
  // Bounds how long read data may linger after the strobe rises
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !rd_latch_strobe_n)
      since_rd <= 4'h0;
    else if (since_rd != 4'hf)
      since_rd <= since_rd + 4'h1;
  end
  AST_NO_FIGHT: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data");
  AST_WR_NO_DRIVE: assert property ((!wr_dir_n &&
    (bus_style_select == hbp_pkg::STYLE_SEP || !rd_latch_strobe_n))
    |-> !dev_data_oe) else $error("device drives in write");
  AST_PIN_RST: assert property (!hw_reset_n [*4]
    |-> !dev_data_oe && !irq_n_oe) else $error("drive in pin reset");
  AST_RST_FLOAT: assert property ($fell(i_srst)
    |-> !irq_n_oe && !dev_data_oe) else $error("drive after reset");
  AST_RD_WINDOW: assert property (dev_data_oe |-> since_rd <= 4'h9)
    else $error("data driven outside read");
  AST_DESEL: assert property (mapper_select_n &&
    transceiver_select_n [*8] |-> !dev_data_oe)
    else $error("data driven unselected");
  AST_STB_WIDTH: assert property ($fell(rd_latch_strobe_n)
    |-> !rd_latch_strobe_n [*8]) else $error("strobe too short");
  AST_ONE_SEL: assert property
    (mapper_select_n || transceiver_select_n) else $error("two selects");
  AST_ADDR_HOLD: assert property ((!rd_latch_strobe_n &&
    !$past(rd_latch_strobe_n)) |-> $stable(host_addr))
    else $error("address moved in strobe");
endmodule
`default_nettype wire

// [bench/host_bus_port_bench.sv]
// Purpose: Runs host bus cycles in both styles through APB orders.
// Assumes: Host end and device end joined by one interface.
// Notes:   Transceiver read data is a fixed function of its address.
`default_nettype none
module host_bus_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, ev = 0, b, b2, xd, xw;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, irq, xwr, perr, prst, xrd;
  logic [9:0] xa_o, xa;
  int miscompares = 0, checked = 0, cycles = 0, xreads = 0;
  hbp_if bus ();
  hbp_host_end i_hbp_host_end (.i_core_clk(clk), .i_srst(srst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .bus(bus));
  hbp_dev_end i_hbp_dev_end (.i_core_clk(clk), .i_srst(srst),
    .bus(bus), .i_events(ev), .i_xcvr_rdata(xa_o[7:0] ^ 8'h5a),
    .o_xcvr_rd(xrd), .o_xcvr_wr(xwr), .o_xcvr_addr(xa_o),
    .o_xcvr_wdata(xd), .o_port_reset(prst));
  hbp_chk i_hbp_chk (.i_core_clk(clk), .i_srst(srst),
    .bus_style_select(bus.bus_style_select),
    .mapper_select_n(bus.mapper_select_n),
    .transceiver_select_n(bus.transceiver_select_n),
    .host_addr(bus.host_addr), .rd_latch_strobe_n(bus.rd_latch_strobe_n),
    .wr_dir_n(bus.wr_dir_n), .hw_reset_n(bus.hw_reset_n),
    .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
    .irq_n_oe(bus.irq_n_oe));
  always #10 clk = ~clk;
  // Last transceiver write address and data, and transceiver read count
  always @(posedge clk) begin
    if (xwr === 1'b1) {xa, xw} <= {xa_o, xd};
    if (xrd === 1'b1) xreads++;
  end
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // One host bus cycle; an event may be injected mid-strobe
  task automatic cyc(input logic rd, xc, input logic [9:0] a,
                     input logic [7:0] d, input logic e,
                     output logic [7:0] q);
    logic [31:0] t;
    apb(1, hbp_pkg::HC_ADDR, {22'h0, a}, t);
    apb(1, hbp_pkg::HC_WDATA, {24'h0, d}, t);
    apb(1, hbp_pkg::HC_CMD, {30'h0, xc, rd}, t);
    if (e) begin
      repeat (8) @(posedge clk);
      ev <= 8'h01;
      @(posedge clk);
      ev <= 8'h00;
    end
    do apb(0, hbp_pkg::HC_STAT, 0, t); while (t[0] !== 1'b0);
    q = t[15:8];
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    apb(1, hbp_pkg::HC_IRQ_MASK, 32'h1, r);
    apb(0, 8'h1c, 0, r);
    chk({31'h0, perr}, 32'h1);
    chk(r, 32'h0);
    for (int s = 0; s < 2; s++) begin
      apb(1, hbp_pkg::HC_CFG, s, r);
      cyc(0, 0, hbp_pkg::DEV_SCRATCH, 8'ha5 ^ s[7:0], 0, b);
      chk(irq, 1'b1);
      apb(0, hbp_pkg::HC_IRQ_STAT, 0, r);
      chk(r[0], 1'b1);
      cyc(1, 0, hbp_pkg::DEV_SCRATCH, 0, 0, b);
      chk(b, 8'ha5 ^ s[7:0]);
      cyc(0, 1, {9'h1e2, ~s[0]}, 8'h69 ^ s[7:0], 0, b);
      chk({xa, xw}, {9'h1e2, ~s[0], 8'h69 ^ s[7:0]});
      cyc(1, 1, 10'h2a7, 0, 0, b);
      chk(b, 8'ha7 ^ 8'h5a);
      chk(xreads, s + 1);
      cyc(1, 0, 10'h3ff, 0, 0, b);
      chk(b, 8'h00);
    end
    cyc(0, 0, hbp_pkg::DEV_MASK, 8'hff, 0, b);
    cyc(0, 0, hbp_pkg::DEV_CTRL, 8'h01, 0, b);
    ev <= 8'h24;
    @(posedge clk) ev <= 8'h00;
    repeat (4) @(posedge clk);
    chk(bus.irq_n, 1'b0);
    apb(0, hbp_pkg::HC_STAT, 0, r);
    chk(r[1:0], 2'b10);
    apb(0, hbp_pkg::HC_IRQ_STAT, 0, r);
    chk(r[1:0], 2'b11);
    cyc(1, 0, hbp_pkg::DEV_STATUS, 0, 1, b);
    chk(b & 8'h24, 8'h24);
    cyc(1, 0, hbp_pkg::DEV_STATUS, 0, 0, b2);
    chk((b | b2) & 8'h01, 8'h01);
    cyc(1, 0, hbp_pkg::DEV_STATUS, 0, 0, b);
    chk({b, bus.irq_n_oe, bus.irq_n}, {8'h00, 2'b11});
    cyc(0, 0, hbp_pkg::DEV_CTRL, 8'h00, 0, b);
    chk(bus.irq_n_oe, 1'b0);
    cyc(0, 0, hbp_pkg::DEV_CTRL, 8'h01, 0, b);
    chk(bus.irq_n_oe, 1'b1);
    apb(1, hbp_pkg::HC_CFG, 32'h5, r);
    repeat (6) @(posedge clk);
    chk({bus.dev_data_oe, bus.irq_n_oe, prst}, 3'b001);
    apb(1, hbp_pkg::HC_CFG, 32'h1, r);
    repeat (6) @(posedge clk);
    cyc(1, 0, hbp_pkg::DEV_CTRL, 0, 0, b);
    chk({b, bus.irq_n_oe, prst}, {8'h00, 2'b00});
    end_of_test;
  end
endmodule
`default_nettype wire

// [verilog/hbp_dev_end.sv]
// Purpose: Device end of the 8-bit parallel host bus port.
// Assumes: Host pins are asynchronous and pass two flip-flops first.
// Notes:   Strobe edges are found on the synchronised pins, so a
//          strobe must stay low for several core clock periods.
//
// Added by the designer: the register addresses and register access over the host bus.
`default_nettype none
module hbp_dev_end (
  input  wire logic       i_core_clk,   // Core clock
  input  wire logic       i_srst,       // Sync reset, active high
  hbp_if.dev              bus,          // Host bus pins
  input  wire logic [7:0] i_events,     // Status event pulses
  input  wire logic [7:0] i_xcvr_rdata, // Transceiver read data
  output logic            o_xcvr_rd,    // Transceiver read pulse
  output logic            o_xcvr_wr,    // Transceiver write pulse
  output logic [9:0]      o_xcvr_addr,  // Transceiver address
  output logic [7:0]      o_xcvr_wdata, // Transceiver write data
  output logic            o_port_reset  // Reset pin seen low
);
  // ---------------------------------------------------------------
  // Types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {D_IDLE, D_READ, D_WRITE} hbp_dstate_type;
  localparam int SW = 2 + 2 + hbp_pkg::ADDR_W + 3 + hbp_pkg::DATA_W;

  // Returns {read active, write active} for the current style
  function automatic logic [1:0] strobe_decode(
    input logic [1:0] style,
    input logic       a_n,
    input logic       b_n
  );
    logic [1:0] r;
    r = 2'h0;
    case (style)
      hbp_pkg::STYLE_SEP: r = {!a_n, !b_n};
      hbp_pkg::STYLE_DS:  r = {!a_n && b_n, !a_n && !b_n};
      default:            r = 2'h0;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;

  always_ff @(posedge i_core_clk) begin
    sync_a <= {bus.bus_style_select, bus.mapper_select_n,
               bus.transceiver_select_n, bus.host_addr,
               bus.rd_latch_strobe_n, bus.wr_dir_n, bus.hw_reset_n,
               bus.data};
    sync_b <= sync_a;
  end

  logic [1:0] s_style;
  logic       s_map_n;
  logic       s_xcvr_n;
  logic [9:0] s_addr;
  logic       s_stb_a_n;
  logic       s_stb_b_n;
  logic       s_rst_n;
  logic [7:0] s_data;

  // Address and data are separate pins; nothing is latched from data
  assign {s_style, s_map_n, s_xcvr_n, s_addr, s_stb_a_n, s_stb_b_n,
          s_rst_n, s_data} = sync_b;

  // ---------------------------------------------------------------
  // Access detection
  // ---------------------------------------------------------------
  logic           lrst;
  logic [1:0]     act;
  logic [1:0]     act_prev;
  logic           sel_map;
  logic           sel_xcvr;
  logic           sel_any;
  hbp_dstate_type state;
  logic           tgt_xcvr;
  logic           rd_start;
  logic           wr_start;
  logic           rd_end;
  logic           wr_end;

  assign lrst     = i_srst || !s_rst_n;
  assign act      = strobe_decode(s_style, s_stb_a_n, s_stb_b_n);
  // Both selects low at once is refused outright
  assign sel_map  = !s_map_n && s_xcvr_n;
  assign sel_xcvr = !s_xcvr_n && s_map_n;
  assign sel_any  = sel_map || sel_xcvr;
  assign rd_start = act[1] && !act_prev[1] && sel_any;
  assign wr_start = act[0] && !act_prev[0] && sel_any;
  assign rd_end   = (state == D_READ) && !act[1];
  assign wr_end   = (state == D_WRITE) && !act[0];

  always_ff @(posedge i_core_clk) begin
    if (lrst) begin
      act_prev <= 2'h3;
    end else begin
      act_prev <= act;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (lrst) begin
      state    <= D_IDLE;
      tgt_xcvr <= 1'b0;
    end else begin
      case (state)
        D_IDLE: begin
          if (rd_start) begin
            state    <= D_READ;
            tgt_xcvr <= sel_xcvr;
          end else if (wr_start) begin
            state    <= D_WRITE;
            tgt_xcvr <= sel_xcvr;
          end
        end
        D_READ: begin
          if (rd_end) begin
            state <= D_IDLE;
          end
        end
        D_WRITE: begin
          if (wr_end) begin
            state <= D_IDLE;
          end
        end
        default: state <= D_IDLE;
      endcase
    end
  end

  // Write lands at the strobe's rising edge, only if still selected
  logic wr_map;
  logic wr_xcvr;
  assign wr_map  = wr_end && !tgt_xcvr && sel_map;
  assign wr_xcvr = wr_end && tgt_xcvr && sel_xcvr;

  // ---------------------------------------------------------------
  // Mapper registers
  // ---------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] ctrl;
  logic [7:0] scratch;
  logic [7:0] rd_value;
  logic       rd_status;
  logic [7:0] status_clr;

  always_ff @(posedge i_core_clk) begin
    if (lrst) begin
      mask    <= hbp_pkg::DEV_RST_VAL;
      ctrl    <= hbp_pkg::DEV_RST_VAL;
      scratch <= hbp_pkg::DEV_RST_VAL;
    end else if (wr_map) begin
      case (s_addr)
        hbp_pkg::DEV_MASK:    mask    <= s_data;
        hbp_pkg::DEV_CTRL:    ctrl    <= s_data;
        hbp_pkg::DEV_SCRATCH: scratch <= s_data;
        default: ;
      endcase
    end
  end

  // Only the bits handed to the host are cleared, so a later event
  // is never dropped; a set in the clearing cycle still wins.
  assign status_clr = (rd_end && rd_status) ? rd_value : 8'h00;

  always_ff @(posedge i_core_clk) begin
    if (lrst) begin
      status <= hbp_pkg::DEV_RST_VAL;
    end else begin
      status <= (status & ~status_clr) | i_events;
    end
  end

  // Read value is frozen at the strobe's falling edge
  always_ff @(posedge i_core_clk) begin
    if (lrst) begin
      rd_value  <= 8'h00;
      rd_status <= 1'b0;
    end else if (state == D_IDLE && rd_start) begin
      rd_status <= sel_map && (s_addr == hbp_pkg::DEV_STATUS);
      if (sel_xcvr) begin
        rd_value <= i_xcvr_rdata;
      end else begin
        case (s_addr)
          hbp_pkg::DEV_STATUS:  rd_value <= status;
          hbp_pkg::DEV_MASK:    rd_value <= mask;
          hbp_pkg::DEV_CTRL:    rd_value <= ctrl;
          hbp_pkg::DEV_LIVE:    rd_value <= i_events;
          hbp_pkg::DEV_SCRATCH: rd_value <= scratch;
          default:              rd_value <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus drivers
  // ---------------------------------------------------------------
  logic irq_active;
  assign irq_active = |(status & mask);

  always_ff @(posedge i_core_clk) begin
    if (lrst) begin
      bus.dev_data_oe  <= 1'b0;
      bus.dev_data_out <= 8'h00;
    end else begin
      // Released as soon as the strobe or the select goes away
      bus.dev_data_oe  <= (state == D_READ) && act[1] &&
                          (tgt_xcvr ? sel_xcvr : sel_map);
      bus.dev_data_out <= rd_value;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (lrst) begin
      bus.irq_n_out <= 1'b1;
      bus.irq_n_oe  <= 1'b0;
    end else begin
      bus.irq_n_out <= !irq_active;
      bus.irq_n_oe  <= irq_active ||
                       ctrl[hbp_pkg::CTRL_IDLE_DRIVE];
    end
  end

  // ---------------------------------------------------------------
  // Transceiver side port
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (lrst) begin
      o_xcvr_rd    <= 1'b0;
      o_xcvr_wr    <= 1'b0;
      o_xcvr_addr  <= 10'h000;
      o_xcvr_wdata <= 8'h00;
    end else begin
      o_xcvr_rd    <= (state == D_IDLE) && rd_start && sel_xcvr;
      o_xcvr_wr    <= wr_xcvr;
      o_xcvr_addr  <= s_addr;
      o_xcvr_wdata <= s_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_port_reset <= 1'b0;
    end else begin
      o_port_reset <= !s_rst_n;
    end
  end
endmodule
`default_nettype wire

// [verilog/hbp_host_end.sv]
// Purpose: Host end that runs parallel bus cycles on APB orders.
// Assumes: APB master per the usual two-phase protocol.
// Notes:   One bus cycle at a time; orders while busy are dropped.
`default_nettype none
module hbp_host_end (
  input  wire logic        i_core_clk, // Core clock
  input  wire logic        i_srst,     // Sync reset, active high
  input  wire logic        i_psel,     // APB select
  input  wire logic        i_penable,  // APB enable
  input  wire logic        i_pwrite,   // APB write
  input  wire logic [7:0]  i_paddr,    // APB byte address
  input  wire logic [31:0] i_pwdata,   // APB write data
  output logic [31:0]      o_prdata,   // APB read data
  output logic             o_pready,   // APB ready
  output logic             o_pslverr,  // APB error, unmapped
  output logic             o_irq,      // Interrupt, active high
  hbp_if.host              bus         // Host bus pins
);
  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_RECOV
  } hbp_hstate_type;

  function automatic logic mapped(input logic [7:0] a);
    return a == hbp_pkg::HC_ADDR || a == hbp_pkg::HC_WDATA ||
           a == hbp_pkg::HC_CFG || a == hbp_pkg::HC_CMD ||
           a == hbp_pkg::HC_STAT || a == hbp_pkg::HC_IRQ_STAT ||
           a == hbp_pkg::HC_IRQ_MASK;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic [8:0] sync_a;
  logic [8:0] sync_b;
  logic       irq_prev;
  always_ff @(posedge i_core_clk) begin
    sync_a <= {bus.irq_n, bus.data};
    sync_b <= sync_a;
  end

  // ---------------------------------------------------------------
  // APB registers
  // ---------------------------------------------------------------
  logic [9:0]     addr;
  logic [7:0]     wdata;
  logic [2:0]     cfg;
  logic [7:0]     rdata;
  logic [1:0]     irq_stat;
  logic [1:0]     irq_mask;
  logic           done_ev;
  logic           dev_ev;
  logic           acc;
  logic           go;
  logic [1:0]     clr;
  hbp_hstate_type state;

  assign acc = i_psel && i_penable && o_pready;
  assign go  = acc && i_pwrite && i_paddr == hbp_pkg::HC_CMD &&
               state == H_IDLE;
  assign clr = (acc && !i_pwrite && i_paddr == hbp_pkg::HC_IRQ_STAT) ?
               o_prdata[1:0] : 2'h0;
  assign dev_ev = irq_prev && !sync_b[8];

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_pready  <= 1'b0;
      o_prdata  <= hbp_pkg::HC_RST_VAL;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && !mapped(i_paddr);
      if (i_psel && i_penable && !o_pready) begin
        case (i_paddr)
          hbp_pkg::HC_ADDR:     o_prdata <= {22'h0, addr};
          hbp_pkg::HC_WDATA:    o_prdata <= {24'h0, wdata};
          hbp_pkg::HC_CFG:      o_prdata <= {29'h0, cfg};
          hbp_pkg::HC_STAT:     o_prdata <= {16'h0, rdata, 6'h0,
                                             !sync_b[8],
                                             state != H_IDLE};
          hbp_pkg::HC_IRQ_STAT: o_prdata <= {30'h0, irq_stat};
          hbp_pkg::HC_IRQ_MASK: o_prdata <= {30'h0, irq_mask};
          default:              o_prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      addr     <= 10'h000;
      wdata    <= 8'h00;
      cfg      <= 3'h0;
      irq_mask <= 2'h0;
    end else if (acc && i_pwrite) begin
      case (i_paddr)
        hbp_pkg::HC_ADDR:     addr     <= i_pwdata[9:0];
        hbp_pkg::HC_WDATA:    wdata    <= i_pwdata[7:0];
        hbp_pkg::HC_CFG:      cfg      <= i_pwdata[2:0];
        hbp_pkg::HC_IRQ_MASK: irq_mask <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Events set over a same-cycle clearing read
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      irq_stat <= 2'h0;
      irq_prev <= 1'b1;
      o_irq    <= 1'b0;
    end else begin
      irq_prev <= sync_b[8];
      irq_stat <= (irq_stat & ~clr) | {dev_ev, done_ev};
      o_irq    <= |(irq_stat & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------
  logic [3:0] cnt;
  logic [1:0] cyc_style;
  logic       cyc_read;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state    <= H_IDLE;
      cnt      <= 4'h0;
      done_ev  <= 1'b0;
      rdata    <= 8'h00;
      cyc_read <= 1'b0;
      cyc_style            <= hbp_pkg::STYLE_SEP;
      bus.mapper_select_n      <= 1'b1;
      bus.transceiver_select_n <= 1'b1;
      bus.rd_latch_strobe_n    <= 1'b1;
      bus.wr_dir_n             <= 1'b1;
      bus.host_addr            <= 10'h000;
      bus.host_data_out        <= 8'h00;
      bus.host_data_oe         <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      case (state)
        H_IDLE: begin
          if (go) begin
            state     <= H_SETUP;
            cnt       <= 4'(hbp_pkg::SETUP_CYC - 1);
            cyc_read  <= i_pwdata[hbp_pkg::CMD_READ];
            cyc_style <= cfg[1:0];
            bus.host_addr     <= addr;
            bus.host_data_out <= wdata;
            bus.host_data_oe  <= !i_pwdata[hbp_pkg::CMD_READ];
            bus.mapper_select_n      <= i_pwdata[hbp_pkg::CMD_XCVR];
            bus.transceiver_select_n <= !i_pwdata[hbp_pkg::CMD_XCVR];
            bus.wr_dir_n <= (cfg[1:0] == hbp_pkg::STYLE_DS) ?
                            i_pwdata[hbp_pkg::CMD_READ] : 1'b1;
          end
        end
        H_SETUP: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h0) begin
            state <= H_STROBE;
            cnt   <= 4'(hbp_pkg::STROBE_CYC - 1);
            if (cyc_style != hbp_pkg::STYLE_SEP || cyc_read) begin
              bus.rd_latch_strobe_n <= 1'b0;
            end else begin
              bus.wr_dir_n <= 1'b0;
            end
          end
        end
        H_STROBE: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h0) begin
            state <= H_HOLD;
            cnt   <= 4'(hbp_pkg::HOLD_CYC - 1);
            rdata <= cyc_read ? sync_b[7:0] : rdata;
            bus.rd_latch_strobe_n <= 1'b1;
            if (cyc_style == hbp_pkg::STYLE_SEP) begin
              bus.wr_dir_n <= 1'b1;
            end
          end
        end
        H_HOLD: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h0) begin
            state <= H_RECOV;
            cnt   <= 4'(hbp_pkg::RECOV_CYC - 1);
            bus.mapper_select_n      <= 1'b1;
            bus.transceiver_select_n <= 1'b1;
            bus.host_data_oe         <= 1'b0;
            bus.wr_dir_n             <= 1'b1;
          end
        end
        H_RECOV: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h0) begin
            state   <= H_IDLE;
            done_ev <= 1'b1;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bus.bus_style_select <= hbp_pkg::STYLE_SEP;
      bus.hw_reset_n       <= 1'b1;
    end else begin
      bus.bus_style_select <= cfg[1:0];
      bus.hw_reset_n       <= !cfg[hbp_pkg::CFG_RESET];
    end
  end
endmodule
`default_nettype wire

// [verilog/hbp_if.sv]
// Purpose: Parallel host bus wires between the host and device ends.
// Assumes: Pull-ups on the data bus and on the interrupt line.
// Notes:   Resolves shared wires from the output enables of both ends.
`default_nettype none
interface hbp_if;
  logic [1:0] bus_style_select;
  logic       mapper_select_n;
  logic       transceiver_select_n;
  logic [9:0] host_addr;
  logic       rd_latch_strobe_n;
  logic       wr_dir_n;
  logic       hw_reset_n;
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic       irq_n_out;
  logic       irq_n_oe;
  logic [7:0] data;
  logic       irq_n;

  // Undriven lines read high through the pull-ups
  assign data  = dev_data_oe  ? dev_data_out :
                 host_data_oe ? host_data_out : 8'hff;
  assign irq_n = (irq_n_oe && !irq_n_out) ? 1'b0 : 1'b1;

  modport dev (
    input  bus_style_select, mapper_select_n, transceiver_select_n,
    input  host_addr, rd_latch_strobe_n, wr_dir_n, hw_reset_n, data,
    output dev_data_out, dev_data_oe, irq_n_out, irq_n_oe
  );
  modport host (
    output bus_style_select, mapper_select_n, transceiver_select_n,
    output host_addr, rd_latch_strobe_n, wr_dir_n, hw_reset_n,
    output host_data_out, host_data_oe,
    input  data, irq_n
  );
endinterface
`default_nettype wire

// [verilog/hbp_pkg.sv]
// Purpose: Shared constants for the host bus port, device and host ends.
// Assumes: Single 50 MHz core clock on both ends.
// Notes:   Bus timing figures are in ns and turned into cycles here.
`default_nettype none
package hbp_pkg;
  // ---------------------------------------------------------------
  // Pin widths and strobe styles
  // ---------------------------------------------------------------
  localparam int         ADDR_W    = 10;
  localparam int         DATA_W    = 8;
  localparam logic [1:0] STYLE_SEP = 2'h0;
  localparam logic [1:0] STYLE_DS  = 2'h1;
  // ---------------------------------------------------------------
  // Device-side map, reached over the host bus
  // ---------------------------------------------------------------
  localparam logic [9:0] DEV_STATUS  = 10'h000;
  localparam logic [9:0] DEV_MASK    = 10'h001;
  localparam logic [9:0] DEV_CTRL    = 10'h002;
  localparam logic [9:0] DEV_LIVE    = 10'h003;
  localparam logic [9:0] DEV_SCRATCH = 10'h004;
  localparam int         CTRL_IDLE_DRIVE = 0;
  localparam logic [7:0] DEV_RST_VAL = 8'h00;
  // ---------------------------------------------------------------
  // Host controller map, reached over APB
  // ---------------------------------------------------------------
  localparam logic [7:0] HC_ADDR     = 8'h00;
  localparam logic [7:0] HC_WDATA    = 8'h04;
  localparam logic [7:0] HC_CFG      = 8'h08;
  localparam logic [7:0] HC_CMD      = 8'h0c;
  localparam logic [7:0] HC_STAT     = 8'h10;
  localparam logic [7:0] HC_IRQ_STAT = 8'h14;
  localparam logic [7:0] HC_IRQ_MASK = 8'h18;
  localparam int CFG_STYLE_LSB = 0;
  localparam int CFG_RESET     = 2;
  localparam int CMD_READ      = 0;
  localparam int CMD_XCVR      = 1;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_IRQ      = 1;
  localparam int STAT_RD_LSB   = 8;
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_DEV       = 1;
  localparam logic [31:0] HC_RST_VAL = 32'h0;
  // ---------------------------------------------------------------
  // Bus cycle timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ   = 50;
  localparam int SETUP_NS  = 60;
  localparam int STROBE_NS = 200;
  localparam int HOLD_NS   = 60;
  localparam int RECOV_NS  = 100;
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int SETUP_CYC  = ns2cyc(SETUP_NS);
  localparam int STROBE_CYC = ns2cyc(STROBE_NS);
  localparam int HOLD_CYC   = ns2cyc(HOLD_NS);
  localparam int RECOV_CYC  = ns2cyc(RECOV_NS);
endpackage
`default_nettype wire
